// *** vtm_pkg.sv ***
// Shared constants, types and helpers for the text video timing and mapper block.
package vtm_pkg;

  // ----------------------------------------------------------------------
  // Clock rates
  // ----------------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ = 50000000;  // Core clock rate, one dot per edge.
  localparam int unsigned DOT_NOM_HZ  = 16000000;  // Nominal crystal dot rate.
  localparam int unsigned DOT_MAX_HZ  = 20000000;  // Highest dot rate to tolerate.

  // ----------------------------------------------------------------------
  // Dot divider and field positions
  // ----------------------------------------------------------------------
  localparam logic [3:0] DIV_TERMINAL  = 4'hf;   // Up-counter value that marks char load.
  localparam logic [3:0] DIV_RESET_VAL = 4'h7;   // Count after reset (nine dots).
  localparam int unsigned COL_LOW_BITS = 4;      // Column bits passed straight through.
  localparam int unsigned HOST_HI_BIT  = 12;     // Host address bit choosing the byte half.
  localparam int unsigned MODE_LSB     = 8;      // First mode bit in the data word.
  localparam logic [1:0] EXT_MODE_CODE = 2'h1;   // Mode bit pair that selects external mode.
  localparam logic [11:0] ADDR_RESET   = 12'h000; // Memory address after reset.
  localparam logic [7:0]  BYTE_RESET   = 8'h00;   // Latched byte after reset.

  // ----------------------------------------------------------------------
  // Composite level, Gray coded from sync up to white
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_SYNC  = 2'h0,  // Blacker than black.
    LVL_BLACK = 2'h1,  // Black picture level.
    LVL_GRAY  = 2'h3,  // Reduced intensity.
    LVL_WHITE = 2'h2   // Full white.
  } level_t;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [6:0] col;     // Column counter bits 0 to 6.
    logic [4:0] row;     // Row counter bits 0 to 4.
    logic       shared;  // Shared column 7 or row 5 output.
  } crt_count_t;

  typedef struct packed {
    logic        sel;    // Host selects display memory.
    logic [12:0] addr;   // Host address inside the 8K window.
  } host_req_t;

  // ----------------------------------------------------------------------
  // Gap-free mapping: row times columns-per-16 plus upper column bits
  // ----------------------------------------------------------------------
  function automatic logic [7:0] map_upper(input logic [5:0] row, input logic [3:0] colhi,
                                           input logic [3:0] xcols);
    logic [10:0] sum;
    // Widen before multiplying so that tall screens do not wrap the product.
    sum = 11'(row) * 11'(xcols) + 11'(colhi);
    return sum[7:0];
  endfunction

endpackage

// *** char_clock_divider.sv ***
// Loadable 4-bit dot divider that produces the character load strobe.
`timescale 1ns/10ps

module char_clock_divider (
  input  wire logic       i_clk,        // Dot clock.
  input  wire logic       i_rst_n,      // Synchronised reset, active low.
  input  wire logic [3:0] i_load_val,   // Switch value, sixteen minus dots.
  input  wire logic       i_run,        // Counter advances while high.
  output logic      [3:0] o_count,      // Present count.
  output logic            o_char_load   // High on the last dot of a character.
);

  logic [3:0] count_r;    // Divider state.
  logic [3:0] count_nxt;  // Next divider state.

  // ----------------------------------------------------------------------
  // Next count: reload at the terminal value, hold while stopped
  // ----------------------------------------------------------------------
  always_comb begin
    count_nxt = count_r;
    if (i_run) begin
      if (count_r == vtm_pkg::DIV_TERMINAL) begin
        count_nxt = i_load_val;
      end else begin
        count_nxt = 4'(count_r + 4'h1);
      end
    end
  end

  // Register only.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_r <= vtm_pkg::DIV_RESET_VAL;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign o_count     = count_r;
  assign o_char_load = (count_r == vtm_pkg::DIV_TERMINAL);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_div_reload: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_char_load && i_run) |=> (count_r == $past(i_load_val)))
    else $error("Divider did not reload the switch value.");

  chk_div_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_run |=> $stable(count_r))
    else $error("Divider moved while stopped.");

endmodule

// *** text_video_timing_and_mapper.sv ***
// Video back end: dot divider, memory mapping, blanking, composite level, external lock.
`timescale 1ns/10ps

// Function
// - Char clock from reloading 4-bit up-counter.
// - One dot per clock, up to 20 MHz.
// - Low four address bits from column directly.
// - Upper address equals row times X plus columns.
// - Shared pin is column 7 or row 5.
// - 16-bit word: character low, attribute high.
// - Lower 4K low byte, upper 4K high.
// - Mode bits pick external generator, disable drivers.
// - Host select ORed into blanking.
// - Select delayed by character clock register first.
// - Either sync forces composite sync level.
// - Pixel one gives white, zero black.
// - White with reduced intensity gives gray.
// - Line end captured, next load stops oscillator.
// - External line edge restarts stopped oscillator.
// - Field end captured, next load stops counter.
// - External field edge restarts stopped counter.
module text_video_timing_and_mapper (
  input  wire logic                I_CORE_CLK,           // Dot clock, 50 MHz.
  input  wire logic                I_RESETN,             // Asynchronous reset, active low.
  input  wire logic [3:0]          I_DOT_LOAD,           // Divider load, sixteen minus dots.
  input  wire logic [3:0]          I_COLS_PER_16,        // Displayed columns over 16, rounded up.
  input  wire logic                I_WIDE_COLS,          // More than 128 columns shown.
  input  wire vtm_pkg::crt_count_t I_CRT_COUNT,          // Controller column and row counters.
  input  wire logic                I_CRT_HSYNC,          // Controller line sync, high active.
  input  wire logic                I_CRT_VSYNC,          // Controller field sync, high active.
  input  wire logic                I_CRT_BLANK,          // Controller retrace blanking.
  input  wire vtm_pkg::host_req_t  I_HOST,               // Host display memory request.
  input  wire logic [15:0]         I_VIDEO_MEM_DATA,     // Word read from display memory.
  input  wire logic                I_PIXEL,              // Serial pixel from video generator.
  input  wire logic                I_REDUCED,            // Reduced intensity request.
  input  wire logic                I_EXT_SYNC_EN,        // Lock to external sync.
  input  wire logic                I_LINE_PULSE_POLARITY, // Inverts external line sync.
  input  wire logic                I_FIELD_POLARITY,     // Inverts external field sync.
  input  wire logic                I_EXT_HSYNC,          // External line sync.
  input  wire logic                I_EXT_VSYNC,          // External field sync.
  output logic                     O_CHAR_LOAD,          // Character load strobe, one dot.
  output logic [11:0]              O_VIDEO_MEM_ADDR,     // Display memory address.
  output logic                     O_LANE_LO,            // Host reaches low byte.
  output logic                     O_LANE_HI,            // Host reaches high byte.
  output logic [7:0]               O_CHAR_CODE,          // Latched character code.
  output logic [7:0]               O_ATTR,               // Latched attribute byte.
  output logic                     O_INT_CHAR_EN,        // Internal character drivers on.
  output logic                     O_EXT_GEN_EN,         // External generator memory on.
  output logic                     O_BLANK,              // Video blanking.
  output vtm_pkg::level_t          O_LEVEL,              // Composite output level.
  output logic                     O_OSC_RUN,            // Dot oscillator running.
  output logic                     O_CNT_EN              // Dot counter enabled.
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_r;  // First reset stage, read only by the second.
  logic rst_n;       // Released reset used everywhere else.

  // Release is synchronised so no flop sees the edge near a clock edge.
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // Dot divider
  // ----------------------------------------------------------------------
  logic       osc_stop_r;   // Oscillator held by line lock.
  logic       cnt_stop_r;   // Counter held by field lock.
  logic       run;          // Dots advance.
  logic       char_load;    // Last dot of a character.
  logic       load_taken;   // Character load that really happens.

  // One dot per core clock; the core clock stands in for the crystal, so any
  // crystal rate up to the rated maximum is simply a slower core clock.
  assign run        = !osc_stop_r && !cnt_stop_r;
  assign load_taken = char_load && run;

  char_clock_divider u_div (
    .i_clk       (I_CORE_CLK),
    .i_rst_n     (rst_n),
    .i_load_val  (I_DOT_LOAD),
    .i_run       (run),
    .o_count     (),
    .o_char_load (char_load)
  );

  // ----------------------------------------------------------------------
  // External lock
  // ----------------------------------------------------------------------
  logic ext_h;                      // Polarity-adjusted external line sync.
  logic ext_v;                      // Polarity-adjusted external field sync.
  logic h_prev_r, h_prev_nxt;       // Previous controller line sync.
  logic v_prev_r, v_prev_nxt;       // Previous controller field sync.
  logic eh_prev_r, eh_prev_nxt;     // Previous external line sync.
  logic ev_prev_r, ev_prev_nxt;     // Previous external field sync.
  logic h_cap_r, h_cap_nxt;         // Line end seen, stop pending.
  logic v_cap_r, v_cap_nxt;         // Field end seen, stop pending.
  logic osc_stop_nxt;               // Next oscillator hold.
  logic cnt_stop_nxt;               // Next counter hold.
  logic eh_fall;                    // Falling external line edge.
  logic ev_fall;                    // Falling external field edge.

  // Polarity inputs are static straps read every cycle.
  assign ext_h   = I_EXT_HSYNC ^ I_LINE_PULSE_POLARITY;
  assign ext_v   = I_EXT_VSYNC ^ I_FIELD_POLARITY;
  assign eh_fall = eh_prev_r && !ext_h;
  assign ev_fall = ev_prev_r && !ext_v;

  // A stop that coincides with a restart edge wins, so the hold never gets lost;
  // the source must then send another edge. Leaving lock mode drops all holds.
  always_comb begin
    h_prev_nxt   = I_CRT_HSYNC;
    v_prev_nxt   = I_CRT_VSYNC;
    eh_prev_nxt  = ext_h;
    ev_prev_nxt  = ext_v;
    h_cap_nxt    = h_cap_r;
    v_cap_nxt    = v_cap_r;
    osc_stop_nxt = osc_stop_r;
    cnt_stop_nxt = cnt_stop_r;
    if (!I_EXT_SYNC_EN) begin
      h_cap_nxt    = 1'b0;
      v_cap_nxt    = 1'b0;
      osc_stop_nxt = 1'b0;
      cnt_stop_nxt = 1'b0;
    end else begin
      if (I_CRT_HSYNC && !h_prev_r) begin
        h_cap_nxt = 1'b1;
      end else if (h_cap_r && load_taken) begin
        h_cap_nxt = 1'b0;
      end
      if (I_CRT_VSYNC && !v_prev_r) begin
        v_cap_nxt = 1'b1;
      end else if (v_cap_r && load_taken) begin
        v_cap_nxt = 1'b0;
      end
      if (h_cap_r && load_taken) begin
        osc_stop_nxt = 1'b1;
      end else if (eh_fall) begin
        osc_stop_nxt = 1'b0;
      end
      if (v_cap_r && load_taken) begin
        cnt_stop_nxt = 1'b1;
      end else if (ev_fall) begin
        cnt_stop_nxt = 1'b0;
      end
    end
  end

  // Register only.
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      h_prev_r   <= 1'b0;
      v_prev_r   <= 1'b0;
      eh_prev_r  <= 1'b0;
      ev_prev_r  <= 1'b0;
      h_cap_r    <= 1'b0;
      v_cap_r    <= 1'b0;
      osc_stop_r <= 1'b0;
      cnt_stop_r <= 1'b0;
    end else begin
      h_prev_r   <= h_prev_nxt;
      v_prev_r   <= v_prev_nxt;
      eh_prev_r  <= eh_prev_nxt;
      ev_prev_r  <= ev_prev_nxt;
      h_cap_r    <= h_cap_nxt;
      v_cap_r    <= v_cap_nxt;
      osc_stop_r <= osc_stop_nxt;
      cnt_stop_r <= cnt_stop_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Address, data and video path
  // ----------------------------------------------------------------------
  logic [5:0]      row6;                    // Row number with shared bit placed.
  logic [3:0]      colhi;                   // Upper column bits with shared bit placed.
  logic [11:0]     addr_r, addr_nxt;        // Display memory address.
  logic            lo_r, lo_nxt;            // Low byte lane.
  logic            hi_r, hi_nxt;            // High byte lane.
  logic [7:0]      char_r, char_nxt;        // Character code.
  logic [7:0]      attr_r, attr_nxt;        // Attribute byte.
  logic            ext_r, ext_nxt;          // External character mode.
  logic            sel_d_r, sel_d_nxt;      // Host select seen at character load.
  vtm_pkg::level_t lvl_r, lvl_nxt;          // Composite level.

  // The one shared controller pin feeds column 7 on wide screens, else row 5.
  assign colhi = {I_WIDE_COLS & I_CRT_COUNT.shared, I_CRT_COUNT.col[6:4]};
  assign row6  = {!I_WIDE_COLS & I_CRT_COUNT.shared, I_CRT_COUNT.row};

  // Host select is resampled only on character loads; memory settles a whole
  // character late, so blanking holds zero to one character time.
  always_comb begin
    addr_nxt  = addr_r;
    lo_nxt    = 1'b0;
    hi_nxt    = 1'b0;
    char_nxt  = char_r;
    attr_nxt  = attr_r;
    ext_nxt   = ext_r;
    sel_d_nxt = sel_d_r;
    if (I_HOST.sel) begin
      addr_nxt = I_HOST.addr[11:0];
      lo_nxt   = !I_HOST.addr[vtm_pkg::HOST_HI_BIT];
      hi_nxt   = I_HOST.addr[vtm_pkg::HOST_HI_BIT];
    end else begin
      addr_nxt[3:0]  = I_CRT_COUNT.col[3:0];
      addr_nxt[11:4] = vtm_pkg::map_upper(row6, colhi, I_COLS_PER_16);
    end
    if (load_taken) begin
      sel_d_nxt = I_HOST.sel;
      char_nxt  = I_VIDEO_MEM_DATA[7:0];
      attr_nxt  = I_VIDEO_MEM_DATA[15:8];
      ext_nxt   = (I_VIDEO_MEM_DATA[vtm_pkg::MODE_LSB +: 2] == vtm_pkg::EXT_MODE_CODE);
    end
    if (I_CRT_HSYNC || I_CRT_VSYNC) begin
      lvl_nxt = vtm_pkg::LVL_SYNC;
    end else if (I_PIXEL && !O_BLANK) begin
      lvl_nxt = I_REDUCED ? vtm_pkg::LVL_GRAY : vtm_pkg::LVL_WHITE;
    end else begin
      lvl_nxt = vtm_pkg::LVL_BLACK;
    end
  end

  // Register only.
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      addr_r  <= vtm_pkg::ADDR_RESET;
      lo_r    <= 1'b0;
      hi_r    <= 1'b0;
      char_r  <= vtm_pkg::BYTE_RESET;
      attr_r  <= vtm_pkg::BYTE_RESET;
      ext_r   <= 1'b0;
      sel_d_r <= 1'b0;
      lvl_r   <= vtm_pkg::LVL_BLACK;
    end else begin
      addr_r  <= addr_nxt;
      lo_r    <= lo_nxt;
      hi_r    <= hi_nxt;
      char_r  <= char_nxt;
      attr_r  <= attr_nxt;
      ext_r   <= ext_nxt;
      sel_d_r <= sel_d_nxt;
      lvl_r   <= lvl_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign O_CHAR_LOAD      = load_taken;
  assign O_VIDEO_MEM_ADDR = addr_r;
  assign O_LANE_LO        = lo_r;
  assign O_LANE_HI        = hi_r;
  assign O_CHAR_CODE      = char_r;
  assign O_ATTR           = attr_r;
  assign O_INT_CHAR_EN    = !ext_r;
  assign O_EXT_GEN_EN     = ext_r;
  assign O_BLANK          = I_CRT_BLANK | sel_d_r;
  assign O_LEVEL          = lvl_r;
  assign O_OSC_RUN        = !osc_stop_r;
  assign O_CNT_EN         = !cnt_stop_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!rst_n);

  chk_addr_direct: assert property (!I_HOST.sel |=>
    O_VIDEO_MEM_ADDR[3:0] == $past(I_CRT_COUNT.col[3:0]))
    else $error("Low address bits do not follow the column.");

  chk_addr_mapped: assert property (!I_HOST.sel |=>
    O_VIDEO_MEM_ADDR[11:4] == vtm_pkg::map_upper($past(row6), $past(colhi),
                                                 $past(I_COLS_PER_16)))
    else $error("Upper address is not row times width plus column.");

  chk_lane_split: assert property (I_HOST.sel |=>
    (O_LANE_HI == $past(I_HOST.addr[12])) && (O_LANE_LO != O_LANE_HI))
    else $error("Host byte lane does not match the 4K half.");

  chk_data_latch: assert property (load_taken |=>
    {O_ATTR, O_CHAR_CODE} == $past(I_VIDEO_MEM_DATA))
    else $error("Data word not latched at character load.");

  chk_ext_gen: assert property (O_EXT_GEN_EN |-> !O_INT_CHAR_EN)
    else $error("Internal drivers on in external mode.");

  chk_blank_delay: assert property ((load_taken && I_HOST.sel) |=>
    O_BLANK throughout (!load_taken)[*2])
    else $error("Host select did not blank the video.");

  chk_sync_level: assert property ((I_CRT_HSYNC || I_CRT_VSYNC) |=>
    O_LEVEL == vtm_pkg::LVL_SYNC)
    else $error("Sync did not force the sync level.");

  chk_pixel_level: assert property ((!I_CRT_HSYNC && !I_CRT_VSYNC
    && I_PIXEL && !O_BLANK) |=>
    O_LEVEL == ($past(I_REDUCED) ? vtm_pkg::LVL_GRAY : vtm_pkg::LVL_WHITE))
    else $error("Lit pixel gave the wrong level.");

  chk_osc_stop: assert property ((I_EXT_SYNC_EN && h_cap_r && load_taken) |=>
    !O_OSC_RUN ##1 !O_CHAR_LOAD)
    else $error("Oscillator did not stop after line end.");

  chk_osc_restart: assert property ((I_EXT_SYNC_EN && osc_stop_r && eh_fall
    && !(h_cap_r && load_taken)) |=> O_OSC_RUN)
    else $error("Oscillator did not restart on the external edge.");

  chk_cnt_stop: assert property ((I_EXT_SYNC_EN && v_cap_r && load_taken) |=>
    !O_CNT_EN)
    else $error("Counter did not stop after field end.");

  chk_cnt_restart: assert property ((I_EXT_SYNC_EN && cnt_stop_r && ev_fall
    && !(v_cap_r && load_taken)) |=> O_CNT_EN)
    else $error("Counter did not resume on the external edge.");

  cov_host_access: cover property (I_HOST.sel ##1 O_LANE_HI);
  cov_line_lock: cover property (!O_OSC_RUN ##[1:300] O_OSC_RUN);
  cov_field_lock: cover property (!O_CNT_EN ##[1:300] O_CNT_EN);
  cov_gray: cover property (O_LEVEL == vtm_pkg::LVL_GRAY);

endmodule

// *** ext_sync_source.sv ***
// Partner model: external sync source that feeds the lock inputs.
`timescale 1ns/10ps

module ext_sync_source (
  input  wire logic i_clk,        // Dot clock.
  input  wire logic i_line_go,    // Request one line pulse.
  input  wire logic i_field_go,   // Request one field pulse.
  input  wire logic i_line_pol,   // Line polarity select.
  input  wire logic i_field_pol,  // Field polarity select.
  output logic      o_ext_hsync,  // External line sync.
  output logic      o_ext_vsync   // External field sync.
);
  logic line_r;   // One-cycle line pulse.
  logic field_r;  // One-cycle field pulse.

  // Each pulse lasts one dot, so its trailing edge is the restart edge.
  always_ff @(posedge i_clk) begin
    line_r  <= i_line_go;
    field_r <= i_field_go;
  end

  // Idle sits at the polarity level, so only a real pulse gives a falling edge.
  assign o_ext_hsync = i_line_pol ^ line_r;
  assign o_ext_vsync = i_field_pol ^ field_r;
endmodule

// *** tb.sv ***
// Self-checking testbench for the text video timing and mapper block.
`timescale 1ns/10ps

module tb;
  logic clk = 1'b0, rst_n = 1'b0, wide = 1'b0, hs = 1'b0, vs = 1'b0, cblank = 1'b0;
  logic pix = 1'b0, red = 1'b0, ext_en = 1'b0, lpol = 1'b0, fpol = 1'b1;
  logic go_line = 1'b0, go_field = 1'b0, ext_hs, ext_vs;
  logic [3:0] dot_load = 4'h7, cols16 = 4'h5;
  logic [15:0] vdata = 16'h0000;
  vtm_pkg::crt_count_t crt = '0;
  vtm_pkg::host_req_t  host = '0;
  logic o_load, o_lo, o_hi, o_int, o_ext, o_blank, o_osc, o_cnt;
  logic [11:0] o_addr;
  logic [7:0]  o_char, o_attr;
  vtm_pkg::level_t o_level;
  int bad_count = 0, checked = 0;
  logic [3:0] tv [5] = '{4'h2, 4'h0, 4'h3, 4'ha, 4'h7};  // Sync H, V, pixel, reduced.
  vtm_pkg::level_t lv [5] = '{vtm_pkg::LVL_WHITE, vtm_pkg::LVL_BLACK, vtm_pkg::LVL_GRAY,
                              vtm_pkg::LVL_SYNC, vtm_pkg::LVL_SYNC};

  initial forever #10 clk = ~clk;

  text_video_timing_and_mapper u_text_video_timing_and_mapper (
    .I_CORE_CLK(clk), .I_RESETN(rst_n), .I_DOT_LOAD(dot_load), .I_COLS_PER_16(cols16),
    .I_WIDE_COLS(wide), .I_CRT_COUNT(crt), .I_CRT_HSYNC(hs), .I_CRT_VSYNC(vs),
    .I_CRT_BLANK(cblank), .I_HOST(host), .I_VIDEO_MEM_DATA(vdata), .I_PIXEL(pix),
    .I_REDUCED(red), .I_EXT_SYNC_EN(ext_en), .I_LINE_PULSE_POLARITY(lpol),
    .I_FIELD_POLARITY(fpol), .I_EXT_HSYNC(ext_hs), .I_EXT_VSYNC(ext_vs),
    .O_CHAR_LOAD(o_load), .O_VIDEO_MEM_ADDR(o_addr), .O_LANE_LO(o_lo), .O_LANE_HI(o_hi),
    .O_CHAR_CODE(o_char), .O_ATTR(o_attr), .O_INT_CHAR_EN(o_int), .O_EXT_GEN_EN(o_ext),
    .O_BLANK(o_blank), .O_LEVEL(o_level), .O_OSC_RUN(o_osc), .O_CNT_EN(o_cnt));

  ext_sync_source u_ext_sync_source (
    .i_clk(clk), .i_line_go(go_line), .i_field_go(go_field), .i_line_pol(lpol),
    .i_field_pol(fpol), .o_ext_hsync(ext_hs), .o_ext_vsync(ext_vs));

  // Compare one value and report a mismatch at once.
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // Selects the strobe or run flag that a bounded wait watches.
  function automatic logic sig(input int k);
    sig = (k == 0) ? o_load : (k == 1) ? o_osc : o_cnt;
  endfunction

  // Waits, a limited number of dots, for a flag to reach a value.
  task automatic wait_for(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(16'(v), 16'(sig(k)));
  endtask

  // Measures the dots between two character loads.
  task automatic period(input logic [15:0] exp);
    int n;
    wait_for(0, 1'b1, 20);
    @(negedge clk);
    n = 1;
    while (o_load !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(exp, 16'(n));
  endtask

  // Ends the run with the verdict.
  task automatic summarize();
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // The main sequence, all inputs changed at the falling edge.
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    period(16'h0009);
    dot_load = 4'ha;
    period(16'h0006);
    crt = '{col: 7'h35, row: 5'h03, shared: 1'b1};
    @(negedge clk);
    chk(16'h0b25, {4'h0, o_addr});
    wide = 1'b1;
    @(negedge clk);
    chk(16'h01a5, {4'h0, o_addr});
    host = '{sel: 1'b1, addr: 13'h1005};
    @(negedge clk);
    chk(16'h2005, {2'h0, o_hi, o_lo, o_addr});
    host = '{sel: 1'b1, addr: 13'h0abc};
    @(negedge clk);
    chk(16'h1abc, {2'h0, o_hi, o_lo, o_addr});
    vdata = 16'h0141;
    wait_for(0, 1'b1, 20);
    @(negedge clk);
    chk(16'h0141, {o_attr, o_char});
    chk(16'h0001, {14'h0, o_int, o_ext});
    chk(16'h0001, {15'h0, o_blank});
    host.sel = 1'b0;
    vdata = 16'h0241;
    wait_for(0, 1'b1, 20);
    @(negedge clk);
    chk(16'h0241, {o_attr, o_char});
    chk(16'h0002, {14'h0, o_int, o_ext});
    chk(16'h0000, {15'h0, o_blank});
    cblank = 1'b1;
    #1 chk(16'h0001, {15'h0, o_blank});
    @(negedge clk);
    cblank = 1'b0;
    for (int i = 0; i < 5; i++) begin
      {hs, vs, pix, red} = tv[i];
      @(negedge clk);
      chk({14'h0, lv[i]}, {14'h0, o_level});
    end
    {hs, vs, pix, red} = 4'h0;
    ext_en = 1'b1;
    @(negedge clk);
    hs = 1'b1;
    wait_for(1, 1'b0, 40);
    hs = 1'b0;
    repeat (3) @(negedge clk);
    chk(16'h0000, {15'h0, o_osc});
    go_line = 1'b1;
    @(negedge clk);
    go_line = 1'b0;
    wait_for(1, 1'b1, 5);
    vs = 1'b1;
    wait_for(2, 1'b0, 40);
    vs = 1'b0;
    go_field = 1'b1;
    @(negedge clk);
    go_field = 1'b0;
    wait_for(2, 1'b1, 5);
    summarize();
  end

  // Watchdog: the whole sequence takes under a hundred dots.
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
endmodule
